// ===== hw/acs_sequencer.sv
// Calibration mode sequencer of the converter with its register port
`timescale 1ns/1ns
// Overview of operation
// - Mode code 1,0,1 enters background calibration on the selected channel, converting on.
// - Background mode interleaves shorted-input zero-scale results so one word leaves per six.
// - Each interleaved zero-scale result updates the zero-scale coefficient by itself.
// - Mode code 1,1,0 runs one zero-scale self-calibration on shorted inputs.
// - Mode code 1,1,1 runs one full-scale self-calibration on the internal reference.
// - After a one-step calibration the mode bits clear to 0,0,0 by themselves.
// - Ready goes high at one-step calibration start and low only when a fresh word follows the end.
module acs_sequencer #(
    parameter int BG_SLOTS = acs_pkg::ACS_BG_SLOTS,
    parameter int CAL_SETTLE = acs_pkg::ACS_CAL_SETTLE
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Register port
    input wire acs_pkg::acs_bus_req_s bus_req,
    output logic [acs_pkg::ACS_DATA_W-1:0] bus_rdata,
    // Filter results
    input wire acs_pkg::acs_result_s filt_res,
    // Front end control
    output acs_pkg::acs_fe_cmd_s fe_cmd,
    // Status pins
    output logic result_ready_n,
    output logic irq
);
    import acs_pkg::*;

    acs_state_s s;
    acs_state_s n;
    logic mode_wr_ok;
    logic cnt_clear;
    logic bg_last;
    logic cal_last;
    logic [ACS_EV_W-1:0] ev;
    logic [ACS_EV_W-1:0] w1c;
    logic [2:0] wr_mode;
    logic [2:0] wr_chan;
    logic one_step_busy;

    assign one_step_busy = (s.seq == ACS_SEQ_CAL_MEAS) || (s.seq == ACS_SEQ_CAL_CONV);
    assign wr_mode = bus_req.wdata[ACS_OP_MODE_POS +: 3];
    assign wr_chan = bus_req.wdata[ACS_CHAN_SEL_POS +: 3];
    assign mode_wr_ok = bus_req.wr && (bus_req.addr == ACS_REG_MODE) && !one_step_busy;
    assign cnt_clear = mode_wr_ok;

    // Slot counter for background interleave
    acs_result_count #(
        .N(BG_SLOTS)
    ) u_bg_slots (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clear(cnt_clear),
        .valid(filt_res.valid && (s.seq == ACS_SEQ_BG) && !mode_wr_ok),
        .last(bg_last)
    );

    // Settling counter for one-step calibration
    acs_result_count #(
        .N(CAL_SETTLE)
    ) u_cal_settle (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clear(cnt_clear),
        .valid(filt_res.valid && (s.seq == ACS_SEQ_CAL_MEAS)),
        .last(cal_last)
    );

    always_comb begin
        n = s;
        n.rdata = '0;
        n.fe.restart = 1'b0;
        ev = '0;
        w1c = '0;

        // Register reads, data one cycle later
        if (bus_req.rd) begin
            case (bus_req.addr)
                ACS_REG_MODE: begin
                    n.rdata[ACS_OP_MODE_POS +: 3] = s.op_mode;
                    n.rdata[ACS_CHAN_SEL_POS +: 3] = s.chan_sel;
                end
                ACS_REG_DATA: begin
                    n.rdata[ACS_WORD_W-1:0] = s.data;
                    n.result_ready_n = 1'b1;
                end
                ACS_REG_ZERO_COEF: n.rdata[ACS_WORD_W-1:0] = s.zero_coef;
                ACS_REG_FULL_COEF: n.rdata[ACS_WORD_W-1:0] = s.full_coef;
                ACS_REG_STATUS: n.rdata[ACS_EV_W-1:0] = s.status;
                ACS_REG_MASK: n.rdata[ACS_EV_W-1:0] = s.mask;
                ACS_REG_STATE: begin
                    n.rdata[0] = s.result_ready_n;
                    n.rdata[1] = one_step_busy;
                    n.rdata[3:2] = s.seq;
                end
                default: n.rdata = '0;
            endcase
        end

        // Register writes other than mode
        if (bus_req.wr) begin
            case (bus_req.addr)
                ACS_REG_ZERO_COEF: n.zero_coef = bus_req.wdata[ACS_WORD_W-1:0];
                ACS_REG_FULL_COEF: n.full_coef = bus_req.wdata[ACS_WORD_W-1:0];
                ACS_REG_STATUS: w1c = bus_req.wdata[ACS_EV_W-1:0];
                ACS_REG_MASK: n.mask = bus_req.wdata[ACS_EV_W-1:0];
                default: w1c = '0;
            endcase
        end

        if (mode_wr_ok) begin
            // Mode write restarts the sequence, pending results dropped
            n.op_mode = wr_mode;
            n.chan_sel = wr_chan;
            n.fe.chan = wr_chan;
            n.fe.restart = 1'b1;
            case (wr_mode)
                ACS_MODE_BG_CAL: begin
                    n.seq = ACS_SEQ_BG;
                    n.fe.sel = ACS_FE_SHORTED;
                end
                ACS_MODE_ZS_SELF: begin
                    n.seq = ACS_SEQ_CAL_MEAS;
                    n.fe.sel = ACS_FE_SHORTED;
                    n.result_ready_n = 1'b1;
                end
                ACS_MODE_FS_SELF: begin
                    n.seq = ACS_SEQ_CAL_MEAS;
                    n.fe.sel = ACS_FE_FULL_REF;
                    n.result_ready_n = 1'b1;
                end
                default: begin
                    n.seq = ACS_SEQ_NORMAL;
                    n.fe.sel = ACS_FE_SIGNAL;
                end
            endcase
        end else if (filt_res.valid) begin
            case (s.seq)
                ACS_SEQ_NORMAL: begin
                    n.data = filt_res.word - s.zero_coef;
                    n.result_ready_n = 1'b0;
                    ev[ACS_EV_WORD] = 1'b1;
                end
                ACS_SEQ_BG: begin
                    if (s.fe.sel == ACS_FE_SHORTED) begin
                        // Zero slot refreshes offset only
                        n.zero_coef = filt_res.word;
                        ev[ACS_EV_BG_UPDATE] = 1'b1;
                        n.fe.sel = ACS_FE_SIGNAL;
                        n.fe.restart = 1'b1;
                    end else if (bg_last) begin
                        // One word out per slot group
                        n.data = filt_res.word - s.zero_coef;
                        n.result_ready_n = 1'b0;
                        ev[ACS_EV_WORD] = 1'b1;
                        n.fe.sel = ACS_FE_SHORTED;
                        n.fe.restart = 1'b1;
                    end
                end
                ACS_SEQ_CAL_MEAS: begin
                    // Data register held meanwhile
                    if (cal_last) begin
                        if (s.op_mode == ACS_MODE_FS_SELF) begin
                            n.full_coef = filt_res.word;
                        end else begin
                            n.zero_coef = filt_res.word;
                        end
                        n.op_mode = ACS_MODE_NORMAL;
                        n.seq = ACS_SEQ_CAL_CONV;
                        n.fe.sel = ACS_FE_SIGNAL;
                        n.fe.restart = 1'b1;
                    end
                end
                ACS_SEQ_CAL_CONV: begin
                    // First fresh word after calibration ends
                    n.data = filt_res.word - s.zero_coef;
                    n.result_ready_n = 1'b0;
                    n.seq = ACS_SEQ_NORMAL;
                    ev[ACS_EV_WORD] = 1'b1;
                    ev[ACS_EV_CAL_DONE] = 1'b1;
                end
                default: n.seq = ACS_SEQ_NORMAL;
            endcase
        end

        // Sticky status, set wins over clear
        n.status = (s.status & ~w1c) | ev;
        n.irq = |(n.status & n.mask);
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s <= '0;
            s.result_ready_n <= ACS_READY_N_RST;
            s.full_coef <= ACS_FULL_COEF_RST;
        end else begin
            s <= n;
        end
    end

    assign bus_rdata = s.rdata;
    assign fe_cmd = s.fe;
    assign result_ready_n = s.result_ready_n;
    assign irq = s.irq;
endmodule

// ===== hw/acs_pkg.sv
// Package for the calibration mode sequencer: register map, fields, types
package acs_pkg;

    // Register bus widths
    localparam int ACS_ADDR_W = 4;
    localparam int ACS_DATA_W = 32;
    localparam int ACS_WORD_W = 24;

    // Register indices on the plain register port
    localparam logic [3:0] ACS_REG_MODE = 4'h0;
    localparam logic [3:0] ACS_REG_DATA = 4'h1;
    localparam logic [3:0] ACS_REG_ZERO_COEF = 4'h2;
    localparam logic [3:0] ACS_REG_FULL_COEF = 4'h3;
    localparam logic [3:0] ACS_REG_STATUS = 4'h4;
    localparam logic [3:0] ACS_REG_MASK = 4'h5;
    localparam logic [3:0] ACS_REG_STATE = 4'h6;

    // Mode register fields: op_mode_bit2..0 and chan_sel_bit2..0
    localparam int ACS_OP_MODE_POS = 0;
    localparam int ACS_CHAN_SEL_POS = 4;

    // Operating mode codes handled here
    localparam logic [2:0] ACS_MODE_NORMAL = 3'h0;
    localparam logic [2:0] ACS_MODE_BG_CAL = 3'h5;
    localparam logic [2:0] ACS_MODE_ZS_SELF = 3'h6;
    localparam logic [2:0] ACS_MODE_FS_SELF = 3'h7;

    // Event bits of status and mask
    localparam int ACS_EV_WORD = 0;
    localparam int ACS_EV_CAL_DONE = 1;
    localparam int ACS_EV_BG_UPDATE = 2;
    localparam int ACS_EV_W = 3;

    // Counts
    localparam int ACS_BG_SLOTS = 6;
    localparam int ACS_CAL_SETTLE = 4;

    // Reset values
    localparam logic ACS_READY_N_RST = 1'b1;
    localparam logic [ACS_WORD_W-1:0] ACS_FULL_COEF_RST = 24'h800000;

    typedef enum logic [1:0] {ACS_SEQ_NORMAL, ACS_SEQ_BG, ACS_SEQ_CAL_MEAS, ACS_SEQ_CAL_CONV}
        acs_seq_e;

    typedef enum logic [1:0] {ACS_FE_SIGNAL, ACS_FE_SHORTED, ACS_FE_FULL_REF} acs_fe_sel_e;

    typedef struct packed {
        logic [ACS_ADDR_W-1:0] addr;
        logic [ACS_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } acs_bus_req_s;

    typedef struct packed {
        acs_fe_sel_e sel;
        logic [2:0] chan;
        logic restart;
    } acs_fe_cmd_s;

    typedef struct packed {
        logic valid;
        logic [ACS_WORD_W-1:0] word;
    } acs_result_s;

    typedef struct packed {
        acs_seq_e seq;
        logic [2:0] op_mode;
        logic [2:0] chan_sel;
        logic [ACS_WORD_W-1:0] data;
        logic [ACS_WORD_W-1:0] zero_coef;
        logic [ACS_WORD_W-1:0] full_coef;
        logic result_ready_n;
        logic [ACS_EV_W-1:0] status;
        logic [ACS_EV_W-1:0] mask;
        logic irq;
        logic [ACS_DATA_W-1:0] rdata;
        acs_fe_cmd_s fe;
    } acs_state_s;

endpackage

// ===== hw/acs_result_count.sv
// Counts filter results and flags the last one of a group
`timescale 1ns/1ns
module acs_result_count #(
    parameter int N = 6
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Control
    input wire logic clear,
    input wire logic valid,
    output logic last
);
    localparam int CW = (N > 1) ? $clog2(N) : 1;
    localparam logic [CW-1:0] CNT_LAST = CW'(N - 1);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;

    assign last = valid && (cnt == CNT_LAST);

    always_comb begin
        next_cnt = cnt;
        if (clear) begin
            next_cnt = '0;
        end else if (last) begin
            next_cnt = '0;
        end else if (valid) begin
            next_cnt = cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule

// ===== hw/acs_unused_placeholder_none.sv
// Spare design file, holds no logic

// ===== verif/acs_sequencer_properties.sv
// Port checks of the calibration mode sequencer
`timescale 1ns/1ns
module acs_sequencer_properties #(
    parameter int BG_SLOTS = acs_pkg::ACS_BG_SLOTS,
    parameter int CAL_SETTLE = acs_pkg::ACS_CAL_SETTLE
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Watched ports
    input wire acs_pkg::acs_bus_req_s bus_req,
    input wire logic [acs_pkg::ACS_DATA_W-1:0] bus_rdata,
    input wire acs_pkg::acs_result_s filt_res,
    input wire acs_pkg::acs_fe_cmd_s fe_cmd,
    input wire logic result_ready_n,
    input wire logic irq
);
    import acs_pkg::*;
    logic mode_any;
    logic [7:0] src_cnt;
    assign mode_any = bus_req.wr && bus_req.addr == ACS_REG_MODE;
    // Results since the last source restart
    always_ff @(posedge clk_sys) begin
        if (!resetn || fe_cmd.restart) begin
            src_cnt <= 8'h00;
        end else if (filt_res.valid) begin
            src_cnt <= src_cnt + 8'h01;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    bg_enter_a: assert property (
        mode_any && !result_ready_n && bus_req.wdata[2:0] == ACS_MODE_BG_CAL |=> fe_cmd.restart
        && fe_cmd.sel == ACS_FE_SHORTED && fe_cmd.chan == $past(bus_req.wdata[6:4]))
        else $error("background entry wrong");
    zs_enter_a: assert property (
        mode_any && !result_ready_n && bus_req.wdata[2:0] == ACS_MODE_ZS_SELF
        |=> result_ready_n && fe_cmd.restart && fe_cmd.sel == ACS_FE_SHORTED)
        else $error("zero-scale entry wrong");
    fs_enter_a: assert property (
        mode_any && !result_ready_n && bus_req.wdata[2:0] == ACS_MODE_FS_SELF |=> result_ready_n
        && fe_cmd.sel == ACS_FE_FULL_REF && fe_cmd.chan == $past(bus_req.wdata[6:4]))
        else $error("full-scale entry wrong");
    fs_busy_a: assert property (fe_cmd.sel == ACS_FE_FULL_REF |-> result_ready_n)
        else $error("ready low during calibration");
    zero_noword_a: assert property (
        filt_res.valid && fe_cmd.sel == ACS_FE_SHORTED |=> !$fell(result_ready_n))
        else $error("word from shorted inputs");
    bg_group_a: assert property (
        fe_cmd.sel == ACS_FE_SHORTED && $past(fe_cmd.sel) == ACS_FE_SIGNAL && !$past(mode_any)
        |-> src_cnt == BG_SLOTS - 1)
        else $error("background group length wrong");
    fs_exit_a: assert property (
        $past(fe_cmd.sel) == ACS_FE_FULL_REF && fe_cmd.sel == ACS_FE_SIGNAL
        |-> fe_cmd.restart && src_cnt == CAL_SETTLE)
        else $error("full-scale exit wrong");
    ready_fall_a: assert property (
        $fell(result_ready_n) |-> $past(filt_res.valid) && $past(fe_cmd.sel) == ACS_FE_SIGNAL)
        else $error("ready fell without a word");
    src_restart_a: assert property (fe_cmd.sel != $past(fe_cmd.sel) |-> fe_cmd.restart)
        else $error("source change without restart");
    rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == '0)
        else $error("read data outside read");
    cover property (mode_any && bus_req.wdata[2:0] == ACS_MODE_BG_CAL);
    cover property ($past(fe_cmd.sel) == ACS_FE_FULL_REF && fe_cmd.sel == ACS_FE_SIGNAL);
    cover property ($rose(irq));
endmodule

bind acs_sequencer acs_sequencer_properties #(.BG_SLOTS(BG_SLOTS), .CAL_SETTLE(CAL_SETTLE))
    i_props (.clk_sys(clk_sys), .resetn(resetn), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .filt_res(filt_res), .fe_cmd(fe_cmd), .result_ready_n(result_ready_n), .irq(irq));

// ===== verif/acs_filter_model.sv
// Filter stand-in: one result every four cycles, word set by the source
`timescale 1ns/1ns
module acs_filter_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Pacing and source
    input wire logic run,
    input wire acs_pkg::acs_fe_cmd_s fe_cmd,
    // Results
    output acs_pkg::acs_result_s filt_res
);
    import acs_pkg::*;
    logic [1:0] tick;
    logic [23:0] src;
    always_comb begin
        case (fe_cmd.sel)
            ACS_FE_SHORTED: src = 24'h000123;
            ACS_FE_FULL_REF: src = 24'h7FFFF0;
            default: src = 24'h400000 + {13'h0000, fe_cmd.chan, 8'h00};
        endcase
    end
    // Word toggles between results so a stale value never looks valid
    always_ff @(posedge clk_sys) begin
        if (!resetn || fe_cmd.restart) begin
            tick <= 2'h0;
            filt_res.valid <= 1'b0;
            filt_res.word <= 24'h000000;
        end else if (run && tick == 2'h3) begin
            tick <= 2'h0;
            filt_res.valid <= 1'b1;
            filt_res.word <= src;
        end else begin
            tick <= tick + {1'b0, run};
            filt_res.valid <= 1'b0;
            filt_res.word <= ~filt_res.word;
        end
    end
endmodule

// ===== verif/acs_sequencer_test.sv
// Self-checking bench of the calibration mode sequencer
`timescale 1ns/1ns
module acs_sequencer_test;
    import acs_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic run = 1'b1;
    acs_bus_req_s bus_req = '0;
    acs_result_s filt_res;
    acs_fe_cmd_s fe_cmd;
    logic [ACS_DATA_W-1:0] bus_rdata;
    logic [31:0] d;
    logic result_ready_n;
    logic irq;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int nv = 0;
    int nv_base = 0;
    always #50 clk_sys = ~clk_sys;
    acs_sequencer i_dut (.clk_sys(clk_sys), .resetn(resetn), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .filt_res(filt_res), .fe_cmd(fe_cmd),
        .result_ready_n(result_ready_n), .irq(irq));
    acs_filter_model i_filt (.clk_sys(clk_sys), .resetn(resetn), .run(run), .fe_cmd(fe_cmd),
        .filt_res(filt_res));
    function automatic logic [31:0] sig(input logic [2:0] c, input logic [23:0] z);
        return {8'h00, 24'h400000 + {13'h0000, c, 8'h00} - z};
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // Filter paused around mode writes so no result meets the restart
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        run <= (a != ACS_REG_MODE);
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
        @(posedge clk_sys);
        run <= 1'b1;
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1 d = bus_rdata;
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        while (result_ready_n !== 1'b0 && n < 300) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk("ready wait", 32'(n < 300), 32'h1);
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (filt_res.valid === 1'b1) begin
            nv++;
        end
        if (cycles == 4000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(ACS_REG_FULL_COEF);
        chk("full coef reset", d, {8'h00, ACS_FULL_COEF_RST});
        rd(ACS_REG_ZERO_COEF);
        chk("zero coef reset", d, 32'h0);
        rd(4'hF);
        chk("unmapped", d, 32'h0);
        wait_rdy();
        wr(ACS_REG_MODE, 32'h27);
        wr(ACS_REG_MODE, 32'h05);
        rd(ACS_REG_DATA);
        chk("data in full cal", d, sig(3'h0, 24'h0));
        rd(ACS_REG_STATE);
        chk("state in full cal", d, 32'hB);
        wait_rdy();
        rd(ACS_REG_MODE);
        chk("mode after full cal", d, 32'h20);
        rd(ACS_REG_DATA);
        chk("data after full cal", d, sig(3'h2, 24'h0));
        rd(ACS_REG_FULL_COEF);
        chk("full coef", d, 32'h007FFFF0);
        rd(ACS_REG_STATUS);
        chk("status", d, 32'h3);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(ACS_REG_MASK, 32'h2);
        chk("irq", {31'h0, irq}, 32'h1);
        rd(ACS_REG_MASK);
        chk("mask", d, 32'h2);
        wr(ACS_REG_STATUS, 32'h2);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        wait_rdy();
        wr(ACS_REG_MODE, 32'h16);
        rd(ACS_REG_DATA);
        chk("data in zero cal", d, sig(3'h2, 24'h0));
        wait_rdy();
        rd(ACS_REG_MODE);
        chk("mode after zero cal", d, 32'h10);
        rd(ACS_REG_ZERO_COEF);
        chk("zero coef", d, 32'h123);
        rd(ACS_REG_DATA);
        chk("data after zero cal", d, sig(3'h1, 24'h123));
        wr(ACS_REG_ZERO_COEF, 32'h0);
        wait_rdy();
        wr(ACS_REG_MODE, 32'h35);
        rd(ACS_REG_DATA);
        wait_rdy();
        nv_base = nv;
        rd(ACS_REG_DATA);
        chk("bg data", d, sig(3'h3, 24'h123));
        wait_rdy();
        chk("results per word", 32'(nv - nv_base), 32'h6);
        rd(ACS_REG_ZERO_COEF);
        chk("bg zero coef", d, 32'h123);
        rd(ACS_REG_MODE);
        chk("bg mode", d, 32'h35);
        rd(ACS_REG_STATUS);
        chk("bg status", d, 32'h7);
        wr(ACS_REG_MODE, 32'h00);
        rd(ACS_REG_MODE);
        chk("normal mode", d, 32'h00);
        results();
    end
endmodule
